/* design/nbcpu_exec.sv */
// Overview of operation
// - Skip next when selected RAM bit zero.
// - Two-word test skips when port bit zero, for Y of four to seven only.
// - Stopped timer1 load sets count and reload.
// - Running timer1 load updates reload only.
// - Timer2 load sets count and low reload.
// - High reload load leaves count untouched.
// - Copy low reload into timer2 count.
// - Timer1 count goes to upper, accumulator.
// - Timer2 count goes to upper, accumulator.
// - Pair register goes to upper, accumulator.
// - Upper and accumulator load pair register.
// - Lookup loads both nibbles of program word.
// - With flag set, bit eight enters carry.
// - Lookup of three cycles or more, page plus pointer address.
// - Load accumulator from RAM, then XOR X.
// - Accumulator low three bits load pointer.
// - Accumulator low two bits select logic.
// - Accumulator loads each pull control register.
// - Accumulator low three bits load timer1 control.
// - Accumulator loads timer2 control register.
// - Set flag enabling bit-eight lookups.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module nbcpu_exec (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [nbcpu_pkg::NBCPU_WORD_W-1:0] instr_word,
	output logic [5:0] ram_addr,
	input wire logic [3:0] ram_rdata,
	output nbcpu_pkg::nbcpu_rom_req_t rom_req,
	input wire logic rom_ack,
	input wire logic [nbcpu_pkg::NBCPU_WORD_W-1:0] rom_rdata,
	output nbcpu_pkg::nbcpu_ctrl_t ctrl,
	output logic [7:0] timer1_count,
	output logic [7:0] timer2_count,
	output logic [nbcpu_pkg::NBCPU_PC_W-1:0] pc,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import nbcpu_pkg::*;

	typedef struct packed {
		nbcpu_fsm_t fsm;
		logic [3:0] acc;
		logic [3:0] upper;
		logic [1:0] x;
		logic [3:0] y;
		logic [2:0] lookup_high;
		logic [7:0] pair;
		logic carry_flag;
		logic [7:0] timer1;
		logic [7:0] timer1_reload;
		logic [7:0] timer2;
		logic [7:0] timer2_low_reload;
		logic [7:0] timer2_high_reload;
		nbcpu_ctrl_t ctrl;
		logic [7:0] port_d;
		logic skip;
		logic [NBCPU_PC_W-1:0] pc;
		nbcpu_rom_req_t rom;
		logic av_ack;
		logic [31:0] av_rdata;
	} nbcpu_state_t;

	nbcpu_state_t state;
	nbcpu_state_t next_state;

	logic stack_push;
	logic stack_pop;
	logic [NBCPU_PC_W-1:0] stack_top;
	logic [$clog2(NBCPU_STACK_DEPTH+1)-1:0] stack_level;
	logic bus_first;
	logic bus_land;

	function automatic logic op_is(input logic [8:0] word, input logic [8:0] code,
			input logic [8:0] mask);
		op_is = (word & mask) == code;
	endfunction : op_is

	function automatic logic [7:0] pair_of(input logic [3:0] hi, input logic [3:0] lo);
		pair_of = {hi, lo};
	endfunction : pair_of

	// Byte registers are split into the upper and accumulator nibbles by these two.
	function automatic logic [3:0] hi_nib(input logic [7:0] b);
		hi_nib = b[7:4];
	endfunction : hi_nib

	function automatic logic [3:0] lo_nib(input logic [7:0] b);
		lo_nib = b[3:0];
	endfunction : lo_nib

	// Indices outside the valid range never skip, whatever the port latch holds.
	function automatic logic port_skip(input logic [3:0] idx, input logic [7:0] latch);
		port_skip = (idx >= NBCPU_PORT_IDX_LO) && (idx <= NBCPU_PORT_IDX_HI)
			&& !latch[idx[2:0]];
	endfunction : port_skip

	nbcpu_stack #(
		.DEPTH(NBCPU_STACK_DEPTH),
		.WIDTH(NBCPU_PC_W)
	) u_stack (
		.clk(clk),
		.rst(rst),
		.push(stack_push),
		.pop(stack_pop),
		.push_data(state.pc),
		.top(stack_top),
		.level(stack_level)
	);

	// A word is taken on the edge where valid and ready are both high, and its effects show
	// in the next cycle. A lookup holds ready low until the program counter is back.
	// Bus writes hold off new instructions, but a lookup answered on the edge a write lands still loads upper and accumulator; a bus write to either wins.
	assign instr_ready = (state.fsm == NBCPU_ST_IDLE || state.fsm == NBCPU_ST_PORT_SECOND)
		&& !avs_write;
	assign ram_addr = {state.x, state.y};
	// The first cycle of a request loads the read data; a write lands one cycle later, on the
	// edge at which the master sees waitrequest low.
	assign bus_first = (avs_read || avs_write) && !state.av_ack;
	assign bus_land = avs_write && state.av_ack;
	assign avs_waitrequest = bus_first;
	assign avs_readdata = state.av_rdata;
	assign rom_req = state.rom;
	assign ctrl = state.ctrl;
	assign timer1_count = state.timer1;
	assign timer2_count = state.timer2;
	assign pc = state.pc;

	logic take;
	logic [1:0] bit_sel;
	logic [7:0] ab_pair;

	always_comb begin
		take = instr_valid && instr_ready;
		bit_sel = instr_word[1:0];
		ab_pair = pair_of(state.upper, state.acc);
		stack_push = 1'b0;
		stack_pop = 1'b0;
		next_state = state;
		if (take) begin
			next_state.pc = state.pc + NBCPU_PC_W'(1);
		end

		unique case (state.fsm)
			NBCPU_ST_IDLE: begin
				if (take && state.skip) begin
					next_state.skip = 1'b0;
				end else if (take) begin
					if (op_is(instr_word, NBCPU_OP_SKIP_RAM_BIT, NBCPU_MASK_J)) begin
						next_state.skip = !ram_rdata[bit_sel];
					end
					if (op_is(instr_word, NBCPU_OP_SKIP_PORT_FIRST, NBCPU_MASK_ALL)) begin
						next_state.fsm = NBCPU_ST_PORT_SECOND;
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_T1, NBCPU_MASK_ALL)) begin
						next_state.timer1_reload = ab_pair;
						if (!state.ctrl.timer1_ctrl[NBCPU_T1_RUN_BIT]) begin
							next_state.timer1 = ab_pair;
						end
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_T2, NBCPU_MASK_ALL)) begin
						next_state.timer2 = ab_pair;
						next_state.timer2_low_reload = ab_pair;
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_T2_HIGH, NBCPU_MASK_ALL)) begin
						next_state.timer2_high_reload = ab_pair;
					end
					if (op_is(instr_word, NBCPU_OP_RELOAD_T2, NBCPU_MASK_ALL)) begin
						next_state.timer2 = state.timer2_low_reload;
					end
					if (op_is(instr_word, NBCPU_OP_READ_T1, NBCPU_MASK_ALL)) begin
						next_state.upper = hi_nib(state.timer1);
						next_state.acc = lo_nib(state.timer1);
					end
					if (op_is(instr_word, NBCPU_OP_READ_T2, NBCPU_MASK_ALL)) begin
						next_state.upper = hi_nib(state.timer2);
						next_state.acc = lo_nib(state.timer2);
					end
					if (op_is(instr_word, NBCPU_OP_READ_PAIR, NBCPU_MASK_ALL)) begin
						next_state.upper = hi_nib(state.pair);
						next_state.acc = lo_nib(state.pair);
					end
					if (op_is(instr_word, NBCPU_OP_WRITE_PAIR, NBCPU_MASK_ALL)) begin
						next_state.pair = ab_pair;
					end
					if (op_is(instr_word, NBCPU_OP_TABLE_LOOKUP, NBCPU_MASK_PAGE)) begin
						// The saved address is that of the lookup word itself.
						stack_push = 1'b1;
						next_state.rom.req = 1'b1;
						next_state.rom.addr = {instr_word[3:0], state.lookup_high,
							state.acc};
						next_state.fsm = NBCPU_ST_LOOKUP_FETCH;
					end
					if (op_is(instr_word, NBCPU_OP_MEM_TO_ACC, NBCPU_MASK_J)) begin
						next_state.acc = ram_rdata;
						next_state.x = state.x ^ bit_sel;
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_LOOKUP_HIGH, NBCPU_MASK_ALL)) begin
						next_state.lookup_high = state.acc[2:0];
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_LOGIC_SEL, NBCPU_MASK_ALL)) begin
						next_state.ctrl.logic_select_reg = state.acc[1:0];
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_PULL_FIRST, NBCPU_MASK_ALL)) begin
						next_state.ctrl.pull_ctrl_first = state.acc;
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_PULL_SECOND, NBCPU_MASK_ALL)) begin
						next_state.ctrl.pull_ctrl_second = state.acc;
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_T1_CTRL, NBCPU_MASK_ALL)) begin
						next_state.ctrl.timer1_ctrl = state.acc[2:0];
					end
					if (op_is(instr_word, NBCPU_OP_LOAD_T2_CTRL, NBCPU_MASK_ALL)) begin
						next_state.ctrl.timer2_ctrl = state.acc;
					end
					if (op_is(instr_word, NBCPU_OP_SET_UPPER_REF, NBCPU_MASK_ALL)) begin
						next_state.ctrl.upper_code_ref_flag = 1'b1;
					end
				end
			end
			NBCPU_ST_PORT_SECOND: begin
				// The second word only completes the test; its content is not decoded.
				if (take) begin
					next_state.fsm = NBCPU_ST_IDLE;
					next_state.skip = port_skip(state.y, state.port_d);
				end
			end
			NBCPU_ST_LOOKUP_FETCH: begin
				// The program memory may take any number of cycles to answer.
				if (rom_ack) begin
					next_state.rom.req = 1'b0;
					next_state.upper = rom_rdata[7:4];
					next_state.acc = rom_rdata[3:0];
					if (state.ctrl.upper_code_ref_flag) begin
						next_state.carry_flag = rom_rdata[NBCPU_ROM_CARRY_BIT];
					end
					next_state.fsm = NBCPU_ST_LOOKUP_RETURN;
				end
			end
			NBCPU_ST_LOOKUP_RETURN: begin
				// Pop and restore share one cycle, so the stack level never lags the counter.
				stack_pop = 1'b1;
				next_state.pc = stack_top;
				next_state.fsm = NBCPU_ST_IDLE;
			end
		endcase

		// Bus slave: one wait cycle, then the answer; a write lands on the answering edge.
		// Register map by word index, narrow fields in the low bits and the rest zero:
		// 0 accumulator, 1 upper nibble, 2 X, 3 Y, 4 carry, 5 port D latch, all writable.
		// 6 pointer high bits over the pair register.
		// 7 timer 1 reload over its count.
		// 8 timer 2 high reload, low reload and count.
		// 9 the control registers as one word.
		// 10 status: state, stack level, skip and program counter.
		// Indices 6 to 10 are read-only so that software cannot bypass the instruction rules.
		// Unmapped indices read zero and ignore writes.
		next_state.av_ack = bus_first;
		if (bus_first) begin
			next_state.av_rdata = '0;
			unique case (avs_address)
				NBCPU_REG_ACC: next_state.av_rdata[3:0] = state.acc;
				NBCPU_REG_UPPER: next_state.av_rdata[3:0] = state.upper;
				NBCPU_REG_X: next_state.av_rdata[1:0] = state.x;
				NBCPU_REG_Y: next_state.av_rdata[3:0] = state.y;
				NBCPU_REG_CARRY: next_state.av_rdata[0] = state.carry_flag;
				NBCPU_REG_PORT_D: next_state.av_rdata[7:0] = state.port_d;
				NBCPU_REG_PAIR: next_state.av_rdata[10:0] = {state.lookup_high, state.pair};
				NBCPU_REG_TIMER1: next_state.av_rdata[15:0] = {state.timer1_reload,
					state.timer1};
				NBCPU_REG_TIMER2: next_state.av_rdata[23:0] = {state.timer2_high_reload,
					state.timer2_low_reload, state.timer2};
				NBCPU_REG_CTRL: next_state.av_rdata[17:0] = state.ctrl;
				NBCPU_REG_STATUS: next_state.av_rdata[16:0] = {state.fsm, stack_level,
					state.skip, state.pc};
				default: next_state.av_rdata = '0;
			endcase
		end
		if (bus_land) begin
			unique case (avs_address)
				NBCPU_REG_ACC: next_state.acc = avs_writedata[3:0];
				NBCPU_REG_UPPER: next_state.upper = avs_writedata[3:0];
				NBCPU_REG_X: next_state.x = avs_writedata[1:0];
				NBCPU_REG_Y: next_state.y = avs_writedata[3:0];
				NBCPU_REG_CARRY: next_state.carry_flag = avs_writedata[0];
				NBCPU_REG_PORT_D: next_state.port_d = avs_writedata[7:0];
				default: next_state.port_d = next_state.port_d;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

endmodule : nbcpu_exec

`default_nettype wire

/* inc/nbcpu_pkg.sv */
package nbcpu_pkg;

	localparam int NBCPU_PC_W = 11;
	localparam int NBCPU_WORD_W = 9;
	localparam int NBCPU_STACK_DEPTH = 4;

	// Opcodes and decode masks, nine bits each.
	localparam logic [8:0] NBCPU_MASK_ALL = 9'h1ff;
	localparam logic [8:0] NBCPU_MASK_J = 9'h1fc;
	localparam logic [8:0] NBCPU_MASK_PAGE = 9'h1f0;
	localparam logic [8:0] NBCPU_OP_SKIP_RAM_BIT = 9'h020;
	localparam logic [8:0] NBCPU_OP_SKIP_PORT_FIRST = 9'h024;
	localparam logic [8:0] NBCPU_OP_SKIP_PORT_SECOND = 9'h02b;
	localparam logic [8:0] NBCPU_OP_LOAD_T1 = 9'h047;
	localparam logic [8:0] NBCPU_OP_LOAD_T2 = 9'h088;
	localparam logic [8:0] NBCPU_OP_LOAD_T2_HIGH = 9'h009;
	localparam logic [8:0] NBCPU_OP_RELOAD_T2 = 9'h053;
	localparam logic [8:0] NBCPU_OP_READ_T1 = 9'h057;
	localparam logic [8:0] NBCPU_OP_READ_T2 = 9'h040;
	localparam logic [8:0] NBCPU_OP_READ_PAIR = 9'h02a;
	localparam logic [8:0] NBCPU_OP_WRITE_PAIR = 9'h01a;
	localparam logic [8:0] NBCPU_OP_TABLE_LOOKUP = 9'h090;
	localparam logic [8:0] NBCPU_OP_MEM_TO_ACC = 9'h064;
	localparam logic [8:0] NBCPU_OP_LOAD_LOOKUP_HIGH = 9'h029;
	localparam logic [8:0] NBCPU_OP_LOAD_LOGIC_SEL = 9'h058;
	localparam logic [8:0] NBCPU_OP_LOAD_PULL_FIRST = 9'h08f;
	localparam logic [8:0] NBCPU_OP_LOAD_PULL_SECOND = 9'h08e;
	localparam logic [8:0] NBCPU_OP_LOAD_T1_CTRL = 9'h03f;
	localparam logic [8:0] NBCPU_OP_LOAD_T2_CTRL = 9'h05a;
	localparam logic [8:0] NBCPU_OP_SET_UPPER_REF = 9'h082;

	// Port-bit test is valid only for these index values.
	localparam logic [3:0] NBCPU_PORT_IDX_LO = 4'h4;
	localparam logic [3:0] NBCPU_PORT_IDX_HI = 4'h7;
	localparam int NBCPU_T1_RUN_BIT = 0;
	localparam int NBCPU_ROM_CARRY_BIT = 8;

	// Register word indices; byte address is four times the index.
	localparam logic [3:0] NBCPU_REG_ACC = 4'h0;
	localparam logic [3:0] NBCPU_REG_UPPER = 4'h1;
	localparam logic [3:0] NBCPU_REG_X = 4'h2;
	localparam logic [3:0] NBCPU_REG_Y = 4'h3;
	localparam logic [3:0] NBCPU_REG_CARRY = 4'h4;
	localparam logic [3:0] NBCPU_REG_PORT_D = 4'h5;
	localparam logic [3:0] NBCPU_REG_PAIR = 4'h6;
	localparam logic [3:0] NBCPU_REG_TIMER1 = 4'h7;
	localparam logic [3:0] NBCPU_REG_TIMER2 = 4'h8;
	localparam logic [3:0] NBCPU_REG_CTRL = 4'h9;
	localparam logic [3:0] NBCPU_REG_STATUS = 4'ha;

	typedef enum logic [1:0] {
		NBCPU_ST_IDLE,
		NBCPU_ST_PORT_SECOND,
		NBCPU_ST_LOOKUP_FETCH,
		NBCPU_ST_LOOKUP_RETURN
	} nbcpu_fsm_t;

	typedef struct packed {
		logic [3:0] pull_ctrl_second;
		logic [3:0] pull_ctrl_first;
		logic [1:0] logic_select_reg;
		logic [3:0] timer2_ctrl;
		logic [2:0] timer1_ctrl;
		logic upper_code_ref_flag;
	} nbcpu_ctrl_t;

	typedef struct packed {
		logic req;
		logic [NBCPU_PC_W-1:0] addr;
	} nbcpu_rom_req_t;

endpackage : nbcpu_pkg

/* design/nbcpu_stack.sv */
`timescale 1ns/1ps
`default_nettype none

module nbcpu_stack #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 11
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic pop,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] top,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int LW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slots;
		logic [LW-1:0] level;
	} nbcpu_stack_state_t;

	nbcpu_stack_state_t state;
	nbcpu_stack_state_t next_state;

	// A push onto a full stack is dropped, as the hardware has no deeper slot.
	always_comb begin
		next_state = state;
		if (push && state.level < LW'(DEPTH)) begin
			next_state.slots[state.level[$clog2(DEPTH)-1:0]] = push_data;
			next_state.level = state.level + LW'(1);
		end else if (pop && state.level != '0) begin
			next_state.level = state.level - LW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		top = '0;
		if (state.level != '0) begin
			top = state.slots[LW'(state.level - LW'(1))];
		end
	end
	assign level = state.level;

endmodule : nbcpu_stack

`default_nettype wire

/* sim/nbcpu_exec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module nbcpu_exec_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [8:0] instr_word,
	input wire nbcpu_pkg::nbcpu_rom_req_t rom_req,
	input wire logic rom_ack,
	input wire nbcpu_pkg::nbcpu_ctrl_t ctrl,
	input wire logic [7:0] timer1_count,
	input wire logic [7:0] timer2_count,
	input wire logic [10:0] pc,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	import nbcpu_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire tk = instr_valid && instr_ready;
	sequence s_ack;
		rom_req.req && rom_ack;
	endsequence
	sequence s_back;
		!instr_ready ##1 (instr_ready || avs_write);
	endsequence
	chk_bus_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Bus answer late.");
	chk_lookup_len: assert property (s_ack |=> s_back)
		else $error("Lookup length wrong.");
	chk_req_hold: assert property (
		rom_req.req && !rom_ack |=> rom_req.req && $stable(rom_req.addr))
		else $error("Program request not held.");
	chk_pc_restore: assert property (s_ack |=> ##1 pc == $past(pc, 2) - 11'h1)
		else $error("Program counter not restored.");
	chk_pc_step: assert property (
		tk && ((instr_word & NBCPU_MASK_PAGE) != NBCPU_OP_TABLE_LOOKUP) |=> pc == $past(pc) + 11'h1)
		else $error("Program counter step wrong.");
	chk_ctrl_cause: assert property ($changed(ctrl) |-> $past(tk))
		else $error("Control changed without instruction.");
	// A running timer1 must never see its count loaded, only its reload.
	chk_t1_cause: assert property ($changed(timer1_count) |->
		$past(tk && instr_word == NBCPU_OP_LOAD_T1 && !ctrl.timer1_ctrl[NBCPU_T1_RUN_BIT]))
		else $error("Timer1 count changed wrongly.");
	chk_t2_cause: assert property ($changed(timer2_count) |->
		$past(tk && (instr_word == NBCPU_OP_LOAD_T2 || instr_word == NBCPU_OP_RELOAD_T2)))
		else $error("Timer2 count changed wrongly.");
endmodule : nbcpu_exec_chk
bind nbcpu_exec nbcpu_exec_chk u_chk (.clk, .rst, .instr_valid, .instr_ready, .instr_word,
	.rom_req, .rom_ack, .ctrl, .timer1_count, .timer2_count, .pc, .avs_read, .avs_write,
	.avs_waitrequest);
`default_nettype wire

/* sim/tb_nbcpu_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_nbcpu_exec;
	import nbcpu_pkg::*;
	logic clk, rst, instr_valid, instr_ready, rom_ack, avs_read, avs_write, avs_waitrequest;
	logic [8:0] instr_word, rom_rdata, v;
	logic [3:0] ram_rdata, avs_address;
	logic [5:0] ram_addr;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] timer1_count, timer2_count;
	logic [10:0] pc, pc0;
	nbcpu_rom_req_t rom_req;
	nbcpu_ctrl_t ctrl;
	logic [3:0] ram [64];
	int error_cnt, compares;
	nbcpu_exec dut (.clk, .rst, .instr_valid, .instr_ready, .instr_word, .ram_addr, .ram_rdata,
		.rom_req, .rom_ack, .rom_rdata, .ctrl, .timer1_count, .timer2_count, .pc, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	assign ram_rdata = ram[ram_addr];
	function automatic logic [8:0] rom_f(input logic [10:0] a);
		return a[8:0] ^ 9'h1a5 ^ {7'h00, a[10:9]};
	endfunction : rom_f
	// Outside the answer cycle the word is inverted so stale data cannot pass.
	always @(posedge clk) begin
		if (rst) begin
			rom_ack <= 1'b0;
			rom_rdata <= 9'h0;
		end else begin
			rom_ack <= rom_req.req && !rom_ack;
			rom_rdata <= (rom_req.req && !rom_ack) ? rom_f(rom_req.addr) : ~rom_f(rom_req.addr);
		end
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic results();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic wt(input logic s);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while ((s ? instr_ready : !avs_waitrequest) !== 1'b1 && i < 40);
		if (i >= 40) begin
			error_cnt++;
			$display("[ERR] wait expected answer seen timeout");
			results();
		end
		rd = avs_readdata;
	endtask : wt
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		wt(1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic ex(input logic [8:0] w);
		instr_valid <= 1'b1;
		instr_word <= w;
		wt(1'b1);
		instr_valid <= 1'b0;
		wt(1'b1);
	endtask : ex
	task automatic ld(input logic [3:0] b, input logic [3:0] a);
		bus(1'b1, NBCPU_REG_UPPER, 32'(b));
		bus(1'b1, NBCPU_REG_ACC, 32'(a));
	endtask : ld
	task automatic rab(input logic [3:0] b, input logic [3:0] a);
		bus(1'b0, NBCPU_REG_UPPER, 32'h0);
		chk("upper", rd, 32'(b));
		bus(1'b0, NBCPU_REG_ACC, 32'h0);
		chk("acc", rd, 32'(a));
	endtask : rab
	task automatic s_reset();
		chk("ctrl", 32'(ctrl), 32'h0);
		bus(1'b1, 4'hf, 32'h5);
		bus(1'b0, 4'hf, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask : s_reset
	task automatic s_timers();
		bus(1'b1, NBCPU_REG_ACC, 32'h8);
		ex(NBCPU_OP_LOAD_T1_CTRL);
		chk("t1 ctrl", 32'(ctrl.timer1_ctrl), 32'h0);
		ld(4'ha, 4'h5);
		ex(NBCPU_OP_LOAD_T1);
		bus(1'b0, NBCPU_REG_TIMER1, 32'h0);
		chk("t1 stopped", rd, 32'ha5a5);
		bus(1'b1, NBCPU_REG_ACC, 32'hf);
		ex(NBCPU_OP_LOAD_T1_CTRL);
		chk("t1 ctrl", 32'(ctrl.timer1_ctrl), 32'h7);
		ld(4'hc, 4'h3);
		ex(NBCPU_OP_LOAD_T1);
		bus(1'b0, NBCPU_REG_TIMER1, 32'h0);
		chk("t1 running", rd, 32'hc3a5);
		ex(NBCPU_OP_READ_T1);
		rab(4'ha, 4'h5);
		ld(4'h9, 4'h6);
		ex(NBCPU_OP_LOAD_T2);
		ld(4'he, 4'h1);
		ex(NBCPU_OP_LOAD_T2_HIGH);
		bus(1'b0, NBCPU_REG_TIMER2, 32'h0);
		chk("t2 loads", rd, 32'he19696);
		ex(NBCPU_OP_WRITE_PAIR);
		ex(NBCPU_OP_RELOAD_T2);
		chk("t2 reload", 32'(timer2_count), 32'h96);
		ld(4'h0, 4'h0);
		ex(NBCPU_OP_READ_PAIR);
		rab(4'he, 4'h1);
		ex(NBCPU_OP_READ_T2);
		rab(4'h9, 4'h6);
	endtask : s_timers
	task automatic s_ctrl();
		bus(1'b1, NBCPU_REG_ACC, 32'he);
		ex(NBCPU_OP_LOAD_LOGIC_SEL);
		ex(NBCPU_OP_LOAD_PULL_FIRST);
		ex(NBCPU_OP_LOAD_LOOKUP_HIGH);
		bus(1'b1, NBCPU_REG_ACC, 32'hb);
		ex(NBCPU_OP_LOAD_PULL_SECOND);
		ex(NBCPU_OP_LOAD_T2_CTRL);
		chk("logic sel", 32'(ctrl.logic_select_reg), 32'h2);
		chk("pull first", 32'(ctrl.pull_ctrl_first), 32'he);
		chk("pull second", 32'(ctrl.pull_ctrl_second), 32'hb);
		chk("t2 ctrl", 32'(ctrl.timer2_ctrl), 32'hb);
		bus(1'b0, NBCPU_REG_PAIR, 32'h0);
		chk("lookup high", 32'(rd[10:8]), 32'h6);
	endtask : s_ctrl
	task automatic s_skip();
		logic [3:0] e;
		logic [7:0] pd;
		e = 4'he;
		pd = 8'h50;
		bus(1'b1, NBCPU_REG_X, 32'h1);
		bus(1'b1, NBCPU_REG_Y, 32'h2);
		ram[6'h12] = 4'h6;
		for (int j = 0; j < 4; j++) begin
			bus(1'b1, NBCPU_REG_ACC, 32'(8 + j));
			ex(NBCPU_OP_SKIP_RAM_BIT | 9'(j));
			ex(NBCPU_OP_LOAD_PULL_FIRST);
			if (ram[6'h12][j])
				e = 4'(8 + j);
			chk("ram skip", 32'(ctrl.pull_ctrl_first), 32'(e));
		end
		e = 4'hb;
		bus(1'b1, NBCPU_REG_PORT_D, 32'(pd));
		for (int j = 3; j < 8; j++) begin
			bus(1'b1, NBCPU_REG_Y, 32'(j));
			bus(1'b1, NBCPU_REG_ACC, 32'(j));
			ex(NBCPU_OP_SKIP_PORT_FIRST);
			ex(NBCPU_OP_SKIP_PORT_SECOND);
			ex(NBCPU_OP_LOAD_PULL_SECOND);
			if (j < 4 || pd[j])
				e = 4'(j);
			chk("port skip", 32'(ctrl.pull_ctrl_second), 32'(e));
		end
	endtask : s_skip
	task automatic s_mem();
		bus(1'b1, NBCPU_REG_Y, 32'h2);
		ram[6'h32] = 4'h9;
		ex(NBCPU_OP_MEM_TO_ACC | 9'h2);
		bus(1'b0, NBCPU_REG_X, 32'h0);
		chk("x xor", rd, 32'h3);
		bus(1'b0, NBCPU_REG_ACC, 32'h0);
		chk("acc mem", rd, 32'h6);
	endtask : s_mem
	task automatic s_look(input logic u);
		bus(1'b1, NBCPU_REG_CARRY, 32'h0);
		bus(1'b1, NBCPU_REG_ACC, 32'hb);
		pc0 = pc;
		ex(NBCPU_OP_TABLE_LOOKUP | 9'h5);
		v = rom_f({4'h5, 3'h6, 4'hb});
		rab(v[7:4], v[3:0]);
		bus(1'b0, NBCPU_REG_CARRY, 32'h0);
		chk("carry", rd, 32'(u & v[8]));
		chk("pc back", 32'(pc), 32'(pc0));
	endtask : s_look
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 9'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		error_cnt = 0;
		compares = 0;
		for (int i = 0; i < 64; i++)
			ram[i] = 4'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_timers();
		s_ctrl();
		s_skip();
		s_mem();
		s_look(1'b0);
		ex(NBCPU_OP_SET_UPPER_REF);
		chk("ref flag", 32'(ctrl.upper_code_ref_flag), 32'h1);
		s_look(1'b1);
		results();
	end
endmodule : tb_nbcpu_exec
`default_nettype wire
